// ==== include/throttle_params.svh ====
// Constants for the package thermal throttle block
// What this block does
// - Any core at trip asserts hot pin.
// - One hot pin for the package.
// - Hot pin policy ignores adaptive enable.
// - Output only after reset; bidir by config.
// - Hot pin is active low.
// - External hot forces minimum voltage/frequency.
// - External hot never engages clock modulation.
// - Control circuit active while external hot held.
// - Optional interrupt on assert and deassert.
// - Fast external toggling pins lowest perf state.
// - Idle entry keeps hot until exit/cool.
// - Deepest idle may drop hot indication.
// - Damage temperature shuts package down.
// - Sustained heat sets critical status, latches sticky, pulses interrupt.
// - Enable bit 4 starts per-core modulation.
// - Duty from bits 3:1, coarse/fine steps.
// - Each core modulated independently.
// - Legacy control modulates all cores together.
// - Internal trip overrides duty with factory.
// - Legacy duty beats per-core duty.
// - Activate at reading zero plus offset.
// - Modulation period fixed 32 microseconds.
`ifndef THROTTLE_PARAMS_SVH
`define THROTTLE_PARAMS_SVH

`define NUM_CORES         4
`define TEMP_W            8
`define OFFSET_W          4
`define DUTY_W            4
`define CLK_PERIOD_NS     10
`define MOD_PERIOD_US     32
`define MOD_PERIOD_CYC    (`MOD_PERIOD_US * 1000 / `CLK_PERIOD_NS)
`define MOD_SLOTS         16
`define SLOT_CYC          (`MOD_PERIOD_CYC / `MOD_SLOTS)
`define SLOT_CNT_W        8
`define TOGGLE_WINDOW_US  1500
`define TOGGLE_WINDOW_CYC (`TOGGLE_WINDOW_US * 1000 / `CLK_PERIOD_NS)
`define TOGGLE_CNT_W      18
`define TCC_FACTORY_DUTY  4'h8
`define CG_EN_BIT         4
`define CG_DUTY_HI        3
`define CG_DUTY_LO        1
`define CG_FINE_BIT       0
`define LEG_EN_BIT        3
`define DUTY_OFF          4'h0

`endif

// ==== include/throttle_pkg.sv ====
// Types shared by the thermal throttle modules
package throttle_pkg;
    typedef enum logic [1:0] {
        MODE_RUN    = 2'b00,
        MODE_TCC    = 2'b01,
        MODE_LEGACY = 2'b10,
        MODE_CORE   = 2'b11
    } mod_mode_t;
endpackage

// ==== include/mod_if.sv ====
// Per-core modulation request and gate signals between control and generator
`timescale 1ns/1ps
`include "throttle_params.svh"
interface mod_if;
    logic [`NUM_CORES-1:0]              enable;
    logic [`NUM_CORES-1:0][`DUTY_W-1:0] duty;
    logic [`NUM_CORES-1:0]              gate;
    modport ctrl (output enable, output duty, input gate);
    modport gen  (input enable, input duty, output gate);
endinterface

// ==== src/clock_modulator.sv ====
// Fixed-period clock modulation generator, one gate per core
`timescale 1ns/1ps
`include "throttle_params.svh"
module clock_modulator
    import throttle_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    mod_if.gen        mif
);
    logic [`SLOT_CNT_W-1:0] slot_cnt_reg;
    logic [`DUTY_W-1:0]     slot_idx_reg;

    // Period counter: 16 slots per period, period independent of core speed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_cnt_reg <= '0;
            slot_idx_reg <= '0;
        end
        else if (slot_cnt_reg == `SLOT_CNT_W'(`SLOT_CYC - 1))
        begin
            slot_cnt_reg <= '0;
            slot_idx_reg <= slot_idx_reg + 4'h1;
        end
        else
        begin
            slot_cnt_reg <= slot_cnt_reg + 8'h01;
        end
    end

    // Each core gets its own gate with its own duty
    genvar c;
    generate
        for (c = 0; c < `NUM_CORES; c++)
        begin : g_core
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    mif.gate[c] <= 1'b1;
                else
                    mif.gate[c] <= !mif.enable[c] || (slot_idx_reg < mif.duty[c]);
            end
        end
    endgenerate
endmodule

// ==== src/thermal_throttle_control.sv ====
// Package thermal protection: hot pin, shutdown, critical status, clock modulation
`timescale 1ns/1ps
`include "throttle_params.svh"
module thermal_throttle_control
    import throttle_pkg::*;
#(
    parameter int TOGGLE_WINDOW = `TOGGLE_WINDOW_CYC
)
(
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    input  wire logic [`NUM_CORES-1:0][`TEMP_W-1:0]   die_temp_sensor,
    input  wire logic [`OFFSET_W-1:0]                 tcc_offset,
    input  wire logic                                 bidir_enable,
    input  wire logic                                 hot_indication_pin_n_in,
    output logic                                      hot_indication_pin_n_out,
    output logic                                      hot_indication_pin_oe_n,
    input  wire logic                                 pkg_idle,
    input  wire logic                                 deepest_package_idle,
    input  wire logic                                 edge_int_assert_en,
    input  wire logic                                 edge_int_deassert_en,
    output logic                                      hot_edge_int,
    input  wire logic                                 damage_temp_in,
    output logic                                      overheat_shutdown_out_n,
    output logic                                      package_shutdown,
    input  wire logic                                 critical_temp_in,
    input  wire logic                                 crit_int_en,
    input  wire logic                                 crit_sticky_clear,
    output logic                                      crit_status,
    output logic                                      crit_sticky,
    output logic                                      thermal_int,
    input  wire logic [`NUM_CORES-1:0][`CG_EN_BIT:0]  clock_gating_control_reg,
    input  wire logic                                 fine_duty_cap,
    input  wire logic [`LEG_EN_BIT:0]                 legacy_clock_control_reg,
    output logic [`NUM_CORES-1:0]                     core_clk_en,
    output logic                                      tcc_active,
    output logic                                      adaptive_vf_req,
    output logic                                      min_vf_req,
    output logic                                      lowest_perf_state
);
    logic [1:0]                  pin_sync_reg;
    logic [1:0]                  damage_sync_reg;
    logic [1:0]                  crit_sync_reg;
    logic                        drive_hot_reg;
    logic [1:0]                  drive_hist_reg;
    logic                        idle_hold_reg;
    logic                        idle_d_reg;
    logic                        ext_hot_reg;
    logic                        pin_level_reg;
    logic [`TOGGLE_CNT_W-1:0]    since_toggle_reg;
    logic                        int_hot_raw;
    logic                        drive_hot_next;
    logic                        ext_hot_next;
    logic                        pin_level_next;
    logic [`NUM_CORES-1:0]       core_trip;
    logic [`DUTY_W-1:0]          legacy_duty;
    mod_mode_t                   mode_reg [`NUM_CORES];
    mod_if                       mif ();

    // Two-flop synchronisers for pin and analog-comparator inputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_sync_reg    <= 2'h3;
            damage_sync_reg <= 2'h0;
            crit_sync_reg   <= 2'h0;
        end
        else
        begin
            pin_sync_reg    <= {pin_sync_reg[0], hot_indication_pin_n_in};
            damage_sync_reg <= {damage_sync_reg[0], damage_temp_in};
            crit_sync_reg   <= {crit_sync_reg[0], critical_temp_in};
        end
    end

    // Per-core trip compare; reading counts down to zero at the limit
    genvar c;
    generate
        for (c = 0; c < `NUM_CORES; c++)
        begin : g_trip
            assign core_trip[c] = die_temp_sensor[c] <= `TEMP_W'(tcc_offset);
        end
    endgenerate
    assign int_hot_raw = |core_trip;

    // Internal hot drive, with idle freeze and deepest-idle release
    always_comb
    begin
        if (deepest_package_idle)
            drive_hot_next = 1'b0;
        else if (idle_hold_reg)
            drive_hot_next = 1'b1;
        else
            drive_hot_next = int_hot_raw;
    end

    // Idle hold set on idle entry while hot, cleared on exit or cool-down
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idle_hold_reg <= 1'b0;
            idle_d_reg    <= 1'b0;
        end
        else
        begin
            idle_d_reg <= pkg_idle;
            if (!pkg_idle || !int_hot_raw)
                idle_hold_reg <= 1'b0;
            else if (!idle_d_reg && drive_hot_reg)
                idle_hold_reg <= 1'b1;
        end
    end

    // Pin driver: push-pull after reset, open-drain once bidirectional
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_hot_reg            <= 1'b0;
            drive_hist_reg           <= 2'h0;
            hot_indication_pin_n_out <= 1'b1;
            hot_indication_pin_oe_n  <= 1'b0;
        end
        else
        begin
            drive_hot_reg  <= drive_hot_next;
            drive_hist_reg <= {drive_hist_reg[0], drive_hot_reg};
            if (bidir_enable)
            begin
                hot_indication_pin_n_out <= 1'b0;
                hot_indication_pin_oe_n  <= !drive_hot_next;
            end
            else
            begin
                hot_indication_pin_n_out <= !drive_hot_next;
                hot_indication_pin_oe_n  <= 1'b0;
            end
        end
    end

    // External assertion: line low while our own drive has been off long enough
    assign ext_hot_next = bidir_enable && !pin_sync_reg[1] && !drive_hot_reg
                          && drive_hist_reg == 2'h0;
    assign pin_level_next = bidir_enable ? !pin_sync_reg[1] : drive_hot_reg;

    // External state, pin level and edge interrupt pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_hot_reg   <= 1'b0;
            pin_level_reg <= 1'b0;
            hot_edge_int  <= 1'b0;
        end
        else
        begin
            ext_hot_reg   <= ext_hot_next;
            pin_level_reg <= pin_level_next;
            hot_edge_int  <= (pin_level_next && !pin_level_reg && edge_int_assert_en)
                          || (!pin_level_next && pin_level_reg && edge_int_deassert_en);
        end
    end

    // Toggle spacing watch on the external drive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            since_toggle_reg  <= `TOGGLE_CNT_W'(TOGGLE_WINDOW);
            lowest_perf_state <= 1'b0;
        end
        else if (ext_hot_next != ext_hot_reg)
        begin
            since_toggle_reg <= '0;
            if (since_toggle_reg < `TOGGLE_CNT_W'(TOGGLE_WINDOW))
                lowest_perf_state <= 1'b1;
        end
        else if (since_toggle_reg < `TOGGLE_CNT_W'(TOGGLE_WINDOW))
        begin
            since_toggle_reg <= since_toggle_reg + 18'h00001;
        end
        else
        begin
            lowest_perf_state <= 1'b0;
        end
    end

    // Control circuit status and voltage/frequency requests
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tcc_active      <= 1'b0;
            adaptive_vf_req <= 1'b0;
            min_vf_req      <= 1'b0;
        end
        else
        begin
            tcc_active      <= int_hot_raw || ext_hot_next;
            adaptive_vf_req <= int_hot_raw;
            min_vf_req      <= ext_hot_next;
        end
    end

    // Catastrophic shutdown latches until reset, whatever modes are on
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overheat_shutdown_out_n <= 1'b1;
            package_shutdown        <= 1'b0;
        end
        else if (damage_sync_reg[1])
        begin
            overheat_shutdown_out_n <= 1'b0;
            package_shutdown        <= 1'b1;
        end
    end

    // Critical status, sticky bit (set beats clear) and interrupt pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            crit_status <= 1'b0;
            crit_sticky <= 1'b0;
            thermal_int <= 1'b0;
        end
        else
        begin
            crit_status <= int_hot_raw && crit_sync_reg[1];
            if (int_hot_raw && crit_sync_reg[1])
                crit_sticky <= 1'b1;
            else if (crit_sticky_clear)
                crit_sticky <= 1'b0;
            thermal_int <= int_hot_raw && crit_sync_reg[1] && !crit_status
                        && crit_int_en;
        end
    end

    // Legacy duty uses coarse steps only
    assign legacy_duty = {legacy_clock_control_reg[`LEG_EN_BIT-1:0], 1'b0};

    // Per-core mode choice and duty; internal control first, then legacy
    generate
        for (c = 0; c < `NUM_CORES; c++)
        begin : g_sel
            logic [`DUTY_W-1:0] core_duty;
            assign core_duty = fine_duty_cap
                ? clock_gating_control_reg[c][`CG_DUTY_HI:`CG_FINE_BIT]
                : {clock_gating_control_reg[c][`CG_DUTY_HI:`CG_DUTY_LO], 1'b0};

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                    mode_reg[c] <= MODE_RUN;
                else if (int_hot_raw)
                    mode_reg[c] <= MODE_TCC;
                else if (legacy_clock_control_reg[`LEG_EN_BIT])
                    mode_reg[c] <= MODE_LEGACY;
                else if (clock_gating_control_reg[c][`CG_EN_BIT])
                    mode_reg[c] <= MODE_CORE;
                else
                    mode_reg[c] <= MODE_RUN;
            end

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    mif.enable[c] <= 1'b0;
                    mif.duty[c]   <= `DUTY_OFF;
                end
                else
                begin
                    unique case (mode_reg[c])
                        MODE_RUN:
                        begin
                            mif.enable[c] <= 1'b0;
                            mif.duty[c]   <= `DUTY_OFF;
                        end
                        MODE_TCC:
                        begin
                            mif.enable[c] <= 1'b1;
                            mif.duty[c]   <= `TCC_FACTORY_DUTY;
                        end
                        MODE_LEGACY:
                        begin
                            mif.enable[c] <= legacy_duty != `DUTY_OFF;
                            mif.duty[c]   <= legacy_duty;
                        end
                        MODE_CORE:
                        begin
                            mif.enable[c] <= core_duty != `DUTY_OFF;
                            mif.duty[c]   <= core_duty;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Shared period generator with one gate flop per core
    clock_modulator u_modulator (
        .clk   (clk),
        .rst_n (rst_n),
        .mif   (mif)
    );

    assign core_clk_en = mif.gate;
endmodule

// ==== sim/thermal_throttle_control_properties.sv ====
// Port-level checker for the thermal throttle block
`timescale 1ns/1ps
`include "throttle_params.svh"
module thermal_throttle_control_properties
    import throttle_pkg::*;
(
    input wire logic                               clk,
    input wire logic                               rst_n,
    input wire logic [`NUM_CORES-1:0][`TEMP_W-1:0] die_temp_sensor,
    input wire logic [`OFFSET_W-1:0]               tcc_offset,
    input wire logic                               bidir_enable,
    input wire logic                               hot_indication_pin_n_in,
    input wire logic                               hot_indication_pin_n_out,
    input wire logic                               hot_indication_pin_oe_n,
    input wire logic                               deepest_package_idle,
    input wire logic                               damage_temp_in,
    input wire logic                               overheat_shutdown_out_n,
    input wire logic                               package_shutdown,
    input wire logic [`NUM_CORES-1:0][`CG_EN_BIT:0] clock_gating_control_reg,
    input wire logic [`LEG_EN_BIT:0]               legacy_clock_control_reg,
    input wire logic [`NUM_CORES-1:0]              core_clk_en,
    input wire logic                               tcc_active,
    input wire logic                               adaptive_vf_req,
    input wire logic                               min_vf_req
);
    logic               trip;
    logic               sw_off;
    logic [`TEMP_W-1:0] off_ext;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Any core at its trip point; no core asking for on-demand gating
    assign off_ext = {{(`TEMP_W-`OFFSET_W){1'b0}}, tcc_offset};
    always_comb
    begin
        trip = 1'b0;
        sw_off = 1'b1;
        for (int i = 0; i < `NUM_CORES; i++)
        begin
            trip = trip | (die_temp_sensor[i] <= off_ext);
            sw_off = sw_off & ~clock_gating_control_reg[i][`CG_EN_BIT];
        end
    end

    // Steps of the external and quiet cases
    sequence s_quiet;
        !adaptive_vf_req && sw_off && !legacy_clock_control_reg[`LEG_EN_BIT];
    endsequence
    sequence s_ext_held;
        bidir_enable && hot_indication_pin_oe_n && !hot_indication_pin_n_in && !trip;
    endsequence

    property p_pp_oe; !bidir_enable && $past(!bidir_enable) |-> !hot_indication_pin_oe_n;
    endproperty
    a_pp_oe: assert property (p_pp_oe) else $error("pin released in output mode");
    property p_trip; trip && !deepest_package_idle && !bidir_enable |=>
        !hot_indication_pin_n_out && adaptive_vf_req && tcc_active; endproperty
    a_trip: assert property (p_trip) else $error("trip did not assert hot pin");
    property p_deep; deepest_package_idle && !bidir_enable |=> hot_indication_pin_n_out;
    endproperty
    a_deep: assert property (p_deep) else $error("hot pin held in deepest idle");
    property p_shut; damage_temp_in |-> ##[1:3] !overheat_shutdown_out_n && package_shutdown;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown on damage heat");
    property p_shut_hold; !overheat_shutdown_out_n |=> !overheat_shutdown_out_n; endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("shutdown released");
    property p_ext; s_ext_held [*6] |-> min_vf_req && tcc_active && !adaptive_vf_req;
    endproperty
    a_ext: assert property (p_ext) else $error("external hot not obeyed");
    property p_no_mod; s_quiet [*6] |-> &core_clk_en; endproperty
    a_no_mod: assert property (p_no_mod) else $error("clock gated with no cause");
    property p_legacy; (legacy_clock_control_reg[`LEG_EN_BIT] && !adaptive_vf_req) [*6]
        |-> core_clk_en == '0 || &core_clk_en; endproperty
    a_legacy: assert property (p_legacy) else $error("cores differ in legacy mode");
endmodule

bind thermal_throttle_control thermal_throttle_control_properties chk_i (
    .clk(clk), .rst_n(rst_n), .die_temp_sensor(die_temp_sensor), .tcc_offset(tcc_offset),
    .bidir_enable(bidir_enable), .hot_indication_pin_n_in(hot_indication_pin_n_in),
    .hot_indication_pin_n_out(hot_indication_pin_n_out),
    .hot_indication_pin_oe_n(hot_indication_pin_oe_n),
    .deepest_package_idle(deepest_package_idle), .damage_temp_in(damage_temp_in),
    .overheat_shutdown_out_n(overheat_shutdown_out_n), .package_shutdown(package_shutdown),
    .clock_gating_control_reg(clock_gating_control_reg),
    .legacy_clock_control_reg(legacy_clock_control_reg), .core_clk_en(core_clk_en),
    .tcc_active(tcc_active), .adaptive_vf_req(adaptive_vf_req), .min_vf_req(min_vf_req));

// ==== sim/hot_pin_partner.sv ====
// Platform-side model of the shared open-drain hot pin
`timescale 1ns/1ps
module hot_pin_partner
(
    input  wire logic pull_low,
    input  wire logic drv_n,
    input  wire logic drv_oe_n,
    output logic      pin_n
);
    // Wired-AND of both pull-downs, pull-up when nobody drives
    // Toggle spacing is left to whoever commands pull_low
    assign pin_n = !(pull_low || (!drv_oe_n && !drv_n));
endmodule

// ==== sim/thermal_throttle_control_tb_top.sv ====
// Self-checking bench for the thermal throttle block
`timescale 1ns/1ps
`include "throttle_params.svh"
`define CMP(n, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module thermal_throttle_control_tb_top
    import throttle_pkg::*;
;
    typedef struct {string n; int id; logic [15:0] e;} note_t;
    localparam int WIN = 50;
    logic                                clk = 1'b0;
    logic                                rst_n = 1'b0;
    logic [`NUM_CORES-1:0][`TEMP_W-1:0]   temp;
    logic [`NUM_CORES-1:0][`CG_EN_BIT:0]  cg;
    logic [`NUM_CORES-1:0]               clk_en;
    logic [`OFFSET_W-1:0]                off;
    logic [`LEG_EN_BIT:0]                leg;
    logic [3:0]                          r;
    logic [9:0]                          f;
    logic bidir, pidle, deep, ea_en, ed_en, dmg, crit, ci_en, cclr, fine, pull;
    logic pin_n, pin_out, oe_n, e_int, oh_n, shut, cst, cstk, tint, thermal_control_circuit, avf, mvf, lps;
    int                                  errors = 0;
    int                                  n_compared = 0;
    int                                  lo[6];
    int                                  k;
    note_t                               q[$];
    note_t                               nx;

    always #5 clk = ~clk;

    thermal_throttle_control #(.TOGGLE_WINDOW(WIN)) thermal_throttle_control_i (
        .clk(clk), .rst_n(rst_n), .die_temp_sensor(temp), .tcc_offset(off),
        .bidir_enable(bidir), .hot_indication_pin_n_in(pin_n),
        .hot_indication_pin_n_out(pin_out), .hot_indication_pin_oe_n(oe_n),
        .pkg_idle(pidle), .deepest_package_idle(deep), .edge_int_assert_en(ea_en),
        .edge_int_deassert_en(ed_en), .hot_edge_int(e_int), .damage_temp_in(dmg),
        .overheat_shutdown_out_n(oh_n), .package_shutdown(shut), .critical_temp_in(crit),
        .crit_int_en(ci_en), .crit_sticky_clear(cclr), .crit_status(cst), .crit_sticky(cstk),
        .thermal_int(tint), .clock_gating_control_reg(cg), .fine_duty_cap(fine),
        .legacy_clock_control_reg(leg), .core_clk_en(clk_en), .tcc_active(thermal_control_circuit),
        .adaptive_vf_req(avf), .min_vf_req(mvf), .lowest_perf_state(lps));
    hot_pin_partner hot_pin_partner_i (.pull_low(pull), .drv_n(pin_out), .drv_oe_n(oe_n),
        .pin_n(pin_n));

    // Observed value for a note: counts below 6, flags from 6 to 15, core clock enables at 16
    function automatic logic [15:0] obs(int id);
        f = {cstk, cst, shut, oh_n, lps, avf, thermal_control_circuit, mvf, oe_n, pin_out};
        if (id < 6) obs = 16'(lo[id]);
        else if (id == 16) obs = {12'h0, clk_en};
        else obs = {15'h0, f[id-6]};
    endfunction
    // Gated cycles per period for a duty of d sixteenths on; zero duty leaves the clock running
    function automatic logic [15:0] exp_lo(int d);
        exp_lo = (d == 0) ? 16'h0 : 16'((`MOD_SLOTS - d) * `SLOT_CYC);
    endfunction
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(string n, int id, logic [15:0] e);
        q.push_back('{n, id, e});
    endtask
    // Lets a new mode land, then counts gated cycles over one whole period
    task automatic measure();
        cyc(6);
        for (int c = 0; c < 4; c++) lo[c] = 0;
        repeat (`MOD_PERIOD_CYC) @(negedge clk) for (int c = 0; c < 4; c++) lo[c] += !clk_en[c];
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Counts pulses and retires pending notes once outputs have settled
    always @(negedge clk)
    begin
        lo[4] += int'(e_int === 1'b1);
        lo[5] += int'(tint === 1'b1);
        while (q.size() > 0)
        begin
            nx = q.pop_front();
            `CMP(nx.n, nx.e, obs(nx.id))
        end
    end

    // Hang guard: far beyond the five measured periods
    initial
    begin
        #(20 * `MOD_PERIOD_CYC * 10);
        errors++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(32'h5B14FA65));
        {bidir, pidle, deep, ed_en, dmg, crit, cclr, fine, pull} = '0;
        {ea_en, ci_en} = 2'b11;
        cg = '0;
        leg = '0;
        lo = '{0, 0, 0, 0, 0, 0};
        for (int c = 0; c < 4; c++) temp[c] = 8'($urandom_range(255, 16));
        off = 4'($urandom_range(15, 0));
        cyc(3);
        chk("pin", 6, 1); chk("oe", 7, 0); chk("ohn", 12, 1); chk("clken", 16, 16'hF);
        @(posedge clk) rst_n <= 1'b1;
        k = $urandom_range(3, 0);
        @(posedge clk) temp[k] <= {4'h0, off};
        cyc(3);
        chk("pin", 6, 0); chk("avf", 10, 1); chk("mvf", 8, 0);
        chk("edge", 4, 1);
        @(posedge clk) pidle <= 1'b1;
        cyc(3); chk("pin", 6, 0);
        @(posedge clk) deep <= 1'b1;
        cyc(3); chk("pin", 6, 1);
        @(posedge clk) {deep, pidle, crit} <= 3'b001;
        @(posedge clk) cg[k] <= 5'h13;
        measure();
        chk("gate", k, exp_lo(`TCC_FACTORY_DUTY));
        chk("cst", 14, 1); chk("cstk", 15, 1); chk("tint", 5, 1);
        @(posedge clk) crit <= 1'b0;
        cyc(5); chk("cst", 14, 0); chk("cstk", 15, 1);
        @(posedge clk) cclr <= 1'b1;
        @(posedge clk) {cclr, temp[k]} <= {1'b0, 8'hFF};
        cyc(4); chk("cstk", 15, 0); chk("pin", 6, 1); chk("edge", 4, 2);
        for (int d = 0; d < 2; d++)
        begin
            r = 4'($urandom_range(15, 1));
            @(posedge clk) {fine, cg[0], cg[1], cg[2]} <= {d[0], 1'b1, r, 5'h14, 1'b0, r};
            measure();
            chk("gate0", 0, exp_lo(d ? r : {r[3:1], 1'b0}));
            chk("gate1", 1, exp_lo(4)); chk("gate2", 2, 0);
        end
        @(posedge clk) leg <= 4'hB;
        measure();
        for (int c = 0; c < 4; c++) chk("gate", c, exp_lo(2 * 3));
        @(posedge clk) {leg, cg, bidir, ed_en, ea_en} <= '0 | 3'b110;
        cyc(8); chk("oe", 7, 1); chk("pin", 6, 0);
        @(posedge clk) pull <= 1'b1;
        measure();
        chk("mvf", 8, 1); chk("tcc", 9, 1); chk("avf", 10, 0); chk("lps", 11, 0);
        for (int c = 0; c < 4; c++) chk("gate", c, 0);
        @(posedge clk) pull <= 1'b0;
        cyc(6); chk("mvf", 8, 0); chk("edge", 4, 3);
        @(posedge clk) pull <= 1'b1;
        cyc(10);
        @(posedge clk) pull <= 1'b0;
        cyc(6); chk("lps", 11, 1);
        cyc(WIN + 10); chk("lps", 11, 0);
        @(posedge clk) dmg <= 1'b1;
        @(posedge clk) dmg <= 1'b0;
        cyc(5); chk("ohn", 12, 0); chk("shut", 13, 1);
        cyc(2);
        wrap_up();
    end
endmodule
